// [logic/reset_and_supply_monitor_control.sv]
// Reset sequencer with supply monitor control and an APB register file.
// Assumes monitor comparator levels and flash attempt pulses are digital inputs.
// Notes on behaviour
// R1 - Reset halts core, inits registers, disables interrupts; int_en_q is kept in non-power resets
// R2 - Data memory untouched; stack pointer reset
// R3 - Port latches all ones, open-drain, pullups on
// R4 - Power and monitor resets drive pin low
// R5 - Exit resets counter and selects internal oscillator
// R6 - Exit enables watchdog at clock over twelve
// R7 - First fetch after release at address zero
// R8 - Supply below threshold holds reset, pin low
// R9 - Power/monitor flag reads one after such reset
// R10 - Power-on enables configurable monitor; others keep it
// R11 - Level monitor always a reset source
// R12 - Unprotected flash erase or write forces reset
// R13 - Software enables monitor, waits, then selects it
// R14 - Monitor reset exit adds no extra delay
// R15 - Software writes select bit one on every write
// R16 - Monitor levels synchronised; power reset asynchronous
`timescale 1ns/10ps
`include "rsm_cfg.svh"

module reset_and_supply_monitor_control (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire rsm_pkg::apb_req_s apb_req,
   output logic [31:0]            prdata_q,
   output logic                   pready_q,
   output logic                   pslverr_q,
   input  wire logic              mon0_below,
   input  wire logic              mon1_below,
   input  wire logic              flash_erase_try,
   input  wire logic              flash_write_try,
   output logic                   core_rst_q,
   output logic                   rst_pin_out_q,
   output logic                   rst_pin_oe_q,
   output logic                   port_force_q,
   output logic [7:0]             port_latch_q,
   output logic                   port_open_drain_q,
   output logic                   pullup_en_q,
   output logic                   defaults_load_q,
   output logic                   osc_internal_q,
   output logic [15:0]            reset_vector_q,
   output logic                   wdt_en_q,
   output logic [3:0]             wdt_div_q,
   output logic                   irq_q
);

   rsm_pkg::rst_state_e        state_q, state_d;
   rsm_pkg::rst_cause_e        cause_q, cause_d;
   logic [`RSM_CNT_W-1:0]      cnt_q;
   logic [1:0]                 m0_s_q, m1_s_q;
   logic                       mon_en_q, mon_hi_q, mon_sel_q;
   logic                       poweron_monitor_reset_flag_q, swrsf_q, ferr_q;
   logic [`RSM_EV_W-1:0]       sts_q, int_en_q, ev;
   logic                       acc, wr, rd, trip, flash_bad, sw_req, mon_low;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   assign acc = apb_req.psel && apb_req.penable && pready_q;
   assign wr  = acc && apb_req.pwrite;
   assign rd  = acc && !apb_req.pwrite;

   // One wait state: pready rises in the second access cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= apb_req.psel && apb_req.penable && !pready_q;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         if (apb_req.psel && apb_req.penable && !pready_q) begin
            if (hit(apb_req.paddr, `RSM_OFS_CTRL)) begin
               prdata_q[`RSM_CTRL_EN] <= mon_en_q;
               prdata_q[`RSM_CTRL_HI] <= mon_hi_q;
            end else if (hit(apb_req.paddr, `RSM_OFS_SRC)) begin
               prdata_q[`RSM_SRC_SEL]   <= mon_sel_q;
               // R9 flag readback
               prdata_q[`RSM_SRC_POWERON_MONITOR_RESET_FLAG] <= poweron_monitor_reset_flag_q;
               prdata_q[`RSM_SRC_SWRST] <= swrsf_q;
               prdata_q[`RSM_SRC_FERR]  <= ferr_q;
            end else if (hit(apb_req.paddr, `RSM_OFS_INT_STS)) begin
               prdata_q[`RSM_EV_W-1:0] <= sts_q;
            end else if (hit(apb_req.paddr, `RSM_OFS_INT_EN)) begin
               prdata_q[`RSM_EV_W-1:0] <= int_en_q;
            end else if (!hit(apb_req.paddr, `RSM_OFS_INT_CLR)) begin
               pslverr_q <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Monitor configuration
   // ----------------------------------------------------------------
   // R10 persists across resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mon_en_q  <= 1'b1;
         mon_hi_q  <= 1'b0;
         mon_sel_q <= 1'b1;
      end else if (wr && hit(apb_req.paddr, `RSM_OFS_CTRL)) begin
         mon_en_q <= apb_req.pwdata[`RSM_CTRL_EN];
         mon_hi_q <= apb_req.pwdata[`RSM_CTRL_HI];
      end else if (wr && hit(apb_req.paddr, `RSM_OFS_SRC)) begin
         // R15 zero here deselects
         mon_sel_q <= apb_req.pwdata[`RSM_SRC_POWERON_MONITOR_RESET_FLAG];
      end
   end

   // R16 two-stage synchronisers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         m0_s_q <= 2'b00;
         m1_s_q <= 2'b00;
      end else begin
         m0_s_q <= {m0_s_q[0], mon0_below};
         m1_s_q <= {m1_s_q[0], mon1_below};
      end
   end

   // ----------------------------------------------------------------
   // Reset causes
   // ----------------------------------------------------------------
   // R8 R11 level monitor unconditional
   assign mon_low   = m1_s_q[1] || (m0_s_q[1] && mon_en_q && mon_sel_q);
   // R12 flash protection check
   assign flash_bad = (flash_erase_try || flash_write_try)
                      && !(mon_en_q && mon_hi_q && mon_sel_q);
   assign sw_req    = wr && hit(apb_req.paddr, `RSM_OFS_SRC)
                      && apb_req.pwdata[`RSM_SRC_SWRST];
   assign trip      = mon_low || flash_bad || sw_req;

   always_comb begin
      state_d = state_q;
      cause_d = cause_q;
      case (state_q)
         rsm_pkg::ST_RUN: begin
            if (mon_low) begin
               state_d = rsm_pkg::ST_HOLD;
               cause_d = rsm_pkg::CAUSE_MON;
            end else if (flash_bad) begin
               state_d = rsm_pkg::ST_HOLD;
               cause_d = rsm_pkg::CAUSE_FLASH;
            end else if (sw_req) begin
               state_d = rsm_pkg::ST_HOLD;
               cause_d = rsm_pkg::CAUSE_SW;
            end
         end
         rsm_pkg::ST_HOLD: begin
            // R14 release on recovery
            if (mon_low) begin
               cause_d = rsm_pkg::CAUSE_MON;
            end else if (cause_q == rsm_pkg::CAUSE_MON) begin
               state_d = rsm_pkg::ST_RUN;
            end else if (cnt_q == `RSM_CNT_W'(`RSM_SHORT_CYC - 1)) begin
               // Flash and software resets last a fixed short count.
               state_d = rsm_pkg::ST_RUN;
            end
         end
         rsm_pkg::ST_DELAY: begin
            if (!mon_low && cnt_q == `RSM_CNT_W'(`RSM_POR_DELAY_CYC - 1)) begin
               state_d = rsm_pkg::ST_RUN;
            end
         end
         default: state_d = rsm_pkg::ST_DELAY;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= rsm_pkg::ST_DELAY;
         cause_q <= rsm_pkg::CAUSE_MON;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cause_q <= cause_d;
         if (state_d != state_q || mon_low) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + `RSM_CNT_W'(1);
         end
      end
   end

   // R9 cause flags latched on entry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         poweron_monitor_reset_flag_q <= 1'b1;
         swrsf_q <= 1'b0;
         ferr_q  <= 1'b0;
      end else if (state_q == rsm_pkg::ST_RUN && trip) begin
         poweron_monitor_reset_flag_q <= mon_low;
         swrsf_q <= !mon_low && !flash_bad;
         ferr_q  <= !mon_low && flash_bad;
      end else if (state_q != rsm_pkg::ST_RUN && mon_low) begin
         // A supply dip during another reset turns it into a monitor reset.
         poweron_monitor_reset_flag_q <= 1'b1;
         swrsf_q <= 1'b0;
         ferr_q  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Reset outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_rst_q        <= 1'b1;
         rst_pin_out_q     <= 1'b0;
         rst_pin_oe_q      <= 1'b1;
         port_force_q      <= 1'b1;
         port_latch_q      <= `RSM_PORT_RST;
         port_open_drain_q <= 1'b1;
         pullup_en_q       <= 1'b1;
      end else begin
         // R1 R2 core halt and register init only
         core_rst_q        <= state_d != rsm_pkg::ST_RUN;
         rst_pin_out_q     <= 1'b0;
         // R4 R8 pin low for power and monitor
         rst_pin_oe_q      <= state_d == rsm_pkg::ST_DELAY
                              || (state_d == rsm_pkg::ST_HOLD
                                  && cause_d == rsm_pkg::CAUSE_MON);
         // R3 ports forced during reset
         port_force_q      <= state_d != rsm_pkg::ST_RUN;
         port_latch_q      <= `RSM_PORT_RST;
         port_open_drain_q <= state_d != rsm_pkg::ST_RUN || port_open_drain_q;
         pullup_en_q       <= 1'b1;
      end
   end

   // R5 R6 R7 defaults applied on exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         defaults_load_q <= 1'b0;
         osc_internal_q  <= 1'b1;
         reset_vector_q  <= `RSM_VECTOR;
         wdt_en_q        <= 1'b1;
         wdt_div_q       <= `RSM_WDT_DIV;
      end else begin
         defaults_load_q <= state_q != rsm_pkg::ST_RUN && state_d == rsm_pkg::ST_RUN;
         osc_internal_q  <= 1'b1;
         reset_vector_q  <= `RSM_VECTOR;
         wdt_en_q        <= 1'b1;
         wdt_div_q       <= `RSM_WDT_DIV;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_comb begin
      ev = '0;
      if (state_q == rsm_pkg::ST_RUN && trip) begin
         ev[`RSM_EV_MON]   = mon_low;
         ev[`RSM_EV_FLASH] = !mon_low && flash_bad;
         ev[`RSM_EV_SW]    = !mon_low && !flash_bad;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sts_q    <= '0;
         int_en_q <= '0;
         irq_q    <= 1'b0;
      end else begin
         // A set in the same cycle as a clear wins.
         if (wr && hit(apb_req.paddr, `RSM_OFS_INT_CLR)) begin
            sts_q <= (sts_q & ~apb_req.pwdata[`RSM_EV_W-1:0]) | ev;
         end else begin
            sts_q <= sts_q | ev;
         end
         if (wr && hit(apb_req.paddr, `RSM_OFS_INT_EN)) begin
            int_en_q <= apb_req.pwdata[`RSM_EV_W-1:0];
         end
         irq_q <= |(sts_q & int_en_q);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_level_mon_hold: assert property (mon1_below [*3] |=> core_rst_q) // R11
      else $error("level monitor did not hold reset");
   a_below_pin_low: assert property (m1_s_q[1] |=> rst_pin_oe_q && core_rst_q) // R8
      else $error("pin not low while supply below");
   a_flash_reset: assert property (state_q == rsm_pkg::ST_RUN && !mon_low && flash_bad
      |=> core_rst_q && !rst_pin_oe_q && ferr_q) // R12
      else $error("flash error reset missing");
   a_pin_with_rst: assert property (rst_pin_oe_q |-> core_rst_q) // R4
      else $error("pin low outside reset");
   a_mon_no_delay: assert property (state_q == rsm_pkg::ST_HOLD
      && cause_q == rsm_pkg::CAUSE_MON && !mon_low |=> !core_rst_q) // R14
      else $error("monitor exit delayed");
   a_exit_defaults: assert property ($fell(core_rst_q) |-> defaults_load_q && wdt_en_q
      && wdt_div_q == 4'hc && reset_vector_q == 16'h0000 && osc_internal_q) // R5
      else $error("exit defaults wrong");
   a_ports_forced: assert property (core_rst_q |-> port_force_q
      && port_latch_q == 8'hff && port_open_drain_q && pullup_en_q) // R3
      else $error("ports not forced in reset");
   a_mon_persist: assert property (!(wr && hit(apb_req.paddr, `RSM_OFS_CTRL))
      |=> $stable(mon_en_q)) // R10
      else $error("monitor enable changed without write");
   a_poweron_monitor_reset_flag_flag: assert property ($fell(core_rst_q) && cause_q == rsm_pkg::CAUSE_MON
      |-> poweron_monitor_reset_flag_q) // R9
      else $error("power flag not set");
   a_sync_stages: assert property (!mon1_below [*2] |=> !m1_s_q[1]) // R16
      else $error("synchroniser depth wrong");
   a_pin_out_low: assert property (!rst_pin_out_q) // R4
      else $error("reset pin driven high");
   a_sw_reset: assert property (sw_req && state_q == rsm_pkg::ST_RUN // R1
      && !mon_low && !flash_bad |=> core_rst_q && !rst_pin_oe_q && swrsf_q)
      else $error("software reset wrong");
   a_poweron_monitor_reset_flag_hold: assert property (state_q != rsm_pkg::ST_RUN && mon_low |=> poweron_monitor_reset_flag_q) // R9
      else $error("power flag lost in hold");
   a_open_drain: assert property (!core_rst_q |-> port_open_drain_q && pullup_en_q) // R3
      else $error("ports left push-pull after reset");
   a_short_exit: assert property (cnt_q == `RSM_CNT_W'(`RSM_SHORT_CYC - 1) && !mon_low // R1
      && state_q == rsm_pkg::ST_HOLD && cause_q != rsm_pkg::CAUSE_MON
      |=> !core_rst_q && defaults_load_q)
      else $error("short reset length wrong");

   // ----------------------------------------------------------------
   // Covers
   // ----------------------------------------------------------------
   c_mon_reset:   cover property (state_q == rsm_pkg::ST_HOLD && cause_q == rsm_pkg::CAUSE_MON);
   c_flash_reset: cover property (state_q == rsm_pkg::ST_HOLD && cause_q == rsm_pkg::CAUSE_FLASH);
   c_sw_reset:    cover property (state_q == rsm_pkg::ST_HOLD && cause_q == rsm_pkg::CAUSE_SW);
   c_por_exit:    cover property ($fell(core_rst_q) && poweron_monitor_reset_flag_q);
   c_level_hold:  cover property (m1_s_q[1] && rst_pin_oe_q);

endmodule

// [logic/rsm_cfg.svh]
// Offsets, field positions, reset values and timing counts for the reset block.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH
`define RSM_OFS_CTRL      8'h00
`define RSM_OFS_SRC       8'h04
`define RSM_OFS_INT_STS   8'h08
`define RSM_OFS_INT_CLR   8'h0c
`define RSM_OFS_INT_EN    8'h10
`define RSM_CTRL_EN       0
`define RSM_CTRL_HI       1
`define RSM_SRC_SEL       0
`define RSM_SRC_POWERON_MONITOR_RESET_FLAG     1
`define RSM_SRC_SWRST     4
`define RSM_SRC_FERR      6
`define RSM_EV_MON        0
`define RSM_EV_FLASH      1
`define RSM_EV_SW         2
`define RSM_EV_W          3
`define RSM_PORT_RST      8'hff
`define RSM_VECTOR        16'h0000
`define RSM_WDT_DIV       4'hc
`define RSM_CLK_MHZ       20
`define RSM_POR_DELAY_US  100
`define RSM_POR_DELAY_CYC (`RSM_POR_DELAY_US * `RSM_CLK_MHZ)
`define RSM_SHORT_CYC     4
`define RSM_CNT_W         12
`endif

// [logic/rsm_pkg.sv]
// Types shared by the reset block: bus request carrier and reset states.
// Assumes the offsets and counts come from rsm_cfg.svh.
package rsm_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_HOLD  = 3'b010,
      ST_DELAY = 3'b100
   } rst_state_e;

   typedef enum logic [1:0] {
      CAUSE_MON   = 2'b00,
      CAUSE_SW    = 2'b01,
      CAUSE_FLASH = 2'b10
   } rst_cause_e;
endpackage

// [verif/supply_core_model.sv]
// Stand-in for the two supply comparators and the core's flash attempts.
// Assumes bench commands change just after a rising clk edge.
`timescale 1ns/10ps

module supply_core_model (
   input  wire logic       clk,
   input  wire logic [1:0] lag,
   input  wire logic       low0_cmd,
   input  wire logic       low1_cmd,
   input  wire logic       erase_cmd,
   input  wire logic       write_cmd,
   output logic            mon0_below,
   output logic            mon1_below,
   output logic            flash_erase_try,
   output logic            flash_write_try
);
   logic [3:0] low0_q;
   logic [3:0] low1_q;

   // Comparator settling is modelled as a selectable lag of clk cycles.
   always_ff @(posedge clk) begin
      low0_q <= {low0_q[2:0], low0_cmd};
      low1_q <= {low1_q[2:0], low1_cmd};
      flash_erase_try <= erase_cmd;
      flash_write_try <= write_cmd;
   end

   assign mon0_below = low0_q[lag];
   assign mon1_below = low1_q[lag];
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the reset and supply monitor block.
// Assumes the register map and bit layout of rsm_cfg.svh.
`timescale 1ns/10ps
`include "rsm_cfg.svh"

module tb_top;
   logic              clk, rst, pready_q, pslverr_q, mon0, mon1, er_try, wr_try;
   logic              core_rst_q, pin_out_q, pin_oe_q, force_q, od_q, pu_q, dload_q;
   logic              osc_q, wdt_en_q, irq_q, low0, low1, erase_cmd, write_cmd;
   logic [31:0]       prdata_q;
   logic [7:0]        latch_q;
   logic [15:0]       vec_q;
   logic [3:0]        div_q;
   logic [1:0]        lag;
   logic [33:0]       mon_e;
   logic [33:0]       exp_q[$];
   rsm_pkg::apb_req_s req;
   int                failures, cmp_count, seed;

   reset_and_supply_monitor_control dut_u (.clk(clk), .rst(rst), .apb_req(req),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .mon0_below(mon0),
      .mon1_below(mon1), .flash_erase_try(er_try), .flash_write_try(wr_try),
      .core_rst_q(core_rst_q), .rst_pin_out_q(pin_out_q), .rst_pin_oe_q(pin_oe_q),
      .port_force_q(force_q), .port_latch_q(latch_q), .port_open_drain_q(od_q),
      .pullup_en_q(pu_q), .defaults_load_q(dload_q), .osc_internal_q(osc_q),
      .reset_vector_q(vec_q), .wdt_en_q(wdt_en_q), .wdt_div_q(div_q), .irq_q(irq_q));

   supply_core_model part_u (.clk(clk), .lag(lag), .low0_cmd(low0), .low1_cmd(low1),
      .erase_cmd(erase_cmd), .write_cmd(write_cmd), .mon0_below(mon0), .mon1_below(mon1),
      .flash_erase_try(er_try), .flash_write_try(wr_try));

   always #25 clk = ~clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic timeout();
      failures++;
      $display("Error at %0t: wait ran out", $time);
      wrap_up();
   endtask

   task automatic note(input string s);
      $display("Test %0s finished", s);
   endtask

   // Expectation holds {is_read, slave_error, read_data}.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int i;
      exp_q.push_back({~wr, e});
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready_q === 1'b1) break;
      end
      req <= '0;
      if (i == 20) timeout();
   endtask

   task automatic wait_core(input logic lvl, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (core_rst_q === lvl) return;
      end
      timeout();
   endtask

   task automatic quiet(input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(negedge clk);
         if (core_rst_q !== 1'b0) bad++;
      end
      chk(bad, 0);
   endtask

   task automatic kick(input logic wr);
      @(posedge clk);
      erase_cmd <= ~wr;
      write_cmd <= wr;
      @(posedge clk);
      erase_cmd <= 1'b0;
      write_cmd <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (pready_q === 1'b1 && exp_q.size() > 0) begin
         mon_e = exp_q.pop_front();
         chk({31'h0, pslverr_q}, {31'h0, mon_e[32]});
         if (mon_e[33]) chk(prdata_q, mon_e[31:0]);
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0; rst = 1'b1; req = '0; lag = 2'd0; low0 = 1'b0; low1 = 1'b0;
      erase_cmd = 1'b0; write_cmd = 1'b0; failures = 0; cmp_count = 0; seed = 33448;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({core_rst_q, pin_oe_q, pin_out_q, force_q, od_q, pu_q, latch_q}, 14'h37ff);
      @(posedge clk);
      rst <= 1'b0;
      wait_core(1'b0, 2100);
      chk({dload_q, force_q, od_q, pu_q, osc_q, wdt_en_q, div_q, vec_q},
          {6'h2f, 4'hc, 16'h0000});
      apb(1'b0, `RSM_OFS_CTRL, 32'h0, 33'h1);
      apb(1'b0, `RSM_OFS_SRC, 32'h0, 33'h3);
      apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000);
      apb(1'b0, `RSM_OFS_INT_CLR, 32'h0, 33'h0);
      apb(1'b1, `RSM_OFS_INT_EN, 32'h7, 33'h0);
      note("power-on");
      for (int k = 0; k < 2; k++) begin
         kick(k[0]);
         wait_core(1'b1, 6);
         chk({31'h0, pin_oe_q}, 32'h0);
         wait_core(1'b0, 10);
      end
      chk({31'h0, irq_q}, 32'h1);
      apb(1'b0, `RSM_OFS_SRC, 32'h0, 33'h41);
      apb(1'b0, `RSM_OFS_INT_STS, 32'h0, 33'h2);
      apb(1'b1, `RSM_OFS_INT_CLR, 32'h2, 33'h0);
      repeat (2) @(negedge clk);
      chk({31'h0, irq_q}, 32'h0);
      apb(1'b0, `RSM_OFS_INT_STS, 32'h0, 33'h0);
      note("flash error");
      // enable at high level first, then select
      apb(1'b1, `RSM_OFS_CTRL, ($random(seed) & 32'hffff_fffc) | 32'h3, 33'h0);
      apb(1'b0, `RSM_OFS_CTRL, 32'h0, 33'h3);
      apb(1'b1, `RSM_OFS_SRC, 32'h2, 33'h0);
      kick(1'b0);
      kick(1'b1);
      quiet(6);
      @(posedge clk) low0 <= 1'b1;
      wait_core(1'b1, 8);
      chk({31'h0, pin_oe_q}, 32'h1);
      @(posedge clk) low0 <= 1'b0;
      wait_core(1'b0, 8);
      chk({31'h0, irq_q}, 32'h1);
      note("monitor reset");
      apb(1'b1, `RSM_OFS_SRC, 32'h12, 33'h0);
      wait_core(1'b1, 8);
      chk({31'h0, pin_oe_q}, 32'h0);
      wait_core(1'b0, 10);
      apb(1'b0, `RSM_OFS_CTRL, 32'h0, 33'h3);
      apb(1'b0, `RSM_OFS_SRC, 32'h0, 33'h11);
      apb(1'b1, `RSM_OFS_CTRL, 32'h0, 33'h0);
      apb(1'b1, `RSM_OFS_SRC, 32'h12, 33'h0);
      wait_core(1'b1, 8);
      wait_core(1'b0, 10);
      apb(1'b0, `RSM_OFS_CTRL, 32'h0, 33'h0);
      note("software reset");
      apb(1'b1, `RSM_OFS_INT_CLR, 32'h7, 33'h0);
      apb(1'b1, `RSM_OFS_INT_EN, 32'h0, 33'h0);
      @(posedge clk) low0 <= 1'b1;
      quiet(8);
      @(posedge clk) begin
         low0 <= 1'b0;
         lag <= 2'd3;
         low1 <= 1'b1;
      end
      wait_core(1'b1, 12);
      chk({30'h0, pin_oe_q, irq_q}, 32'h2);
      @(posedge clk) low1 <= 1'b0;
      wait_core(1'b0, 12);
      apb(1'b0, `RSM_OFS_INT_STS, 32'h0, 33'h1);
      apb(1'b0, `RSM_OFS_SRC, 32'h0, 33'h3);
      apb(1'b1, `RSM_OFS_INT_EN, 32'h1, 33'h0);
      repeat (2) @(negedge clk);
      chk({31'h0, irq_q}, 32'h1);
      note("level monitor");
      repeat (4) @(posedge clk);
      wrap_up();
   end
endmodule
